//--- pinctl_pkg.sv
// Purpose: Shared constants and types for the DRAM pin control block
// Assumes: One 100 MHz system clock; link crossings arrive as enable pulses
// Notes: Command codes follow the strobe lines with chip select in front

package pinctl_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 14;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // Address bit positions with meaning in particular commands
    localparam int PRECHARGE_ALL_POS = 10;
    localparam int EMR1_TERM_LO_POS = 2;
    localparam int EMR1_TERM_HI_POS = 6;
    localparam int EMR1_ALT_STROBE_POS = 11;

    // Bank select value that steers a mode register set to the first extended register
    localparam logic [BANK_W-1:0] EXT_MODE_REG_ONE_SEL = 3'h1;
    localparam logic [BANK_W-1:0] MODE_REG_SEL = 3'h0;

    // Values after reset
    localparam logic [1:0] EMR1_TERM_RESET = 2'h0;
    localparam logic EMR1_ALT_STROBE_RESET = 1'b0;
    localparam logic [NUM_BANKS-1:0] OPEN_BANKS_RESET = 8'h00;

    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_MODE_SET
    } cmd_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_PRECHARGE_PD,
        PWR_ACTIVE_PD,
        PWR_SELF_REFRESH
    } pwr_t;

endpackage

//--- cmd_decode.sv
// Purpose: Turns chip select and the three strobe lines into a command
// Assumes: Inputs already sampled at one clock crossing
// Notes: Purely combinational; the caller registers the result

`timescale 1ns/1ps

module cmd_decode
    import pinctl_pkg::*;
(
    input wire logic cs_n_i,
    input wire logic row_strobe_n_i,
    input wire logic col_strobe_n_i,
    input wire logic write_en_n_i,
    output cmd_t cmd_o
);

    always_comb begin
        // Chip select high masks every command
        if (cs_n_i) begin
            cmd_o = CMD_DESELECT;
        end else begin
            unique case ({row_strobe_n_i, col_strobe_n_i, write_en_n_i})
                3'b111: cmd_o = CMD_NOP;
                3'b011: cmd_o = CMD_ACTIVATE;
                3'b101: cmd_o = CMD_READ;
                3'b100: cmd_o = CMD_WRITE;
                3'b010: cmd_o = CMD_PRECHARGE;
                3'b001: cmd_o = CMD_REFRESH;
                3'b000: cmd_o = CMD_MODE_SET;
                default: cmd_o = CMD_NOP;
            endcase
        end
    end

endmodule

//--- beat_fifo.sv
// Purpose: Holds accepted write beats until the array side takes them
// Assumes: Single clock, synchronous active high reset
// Notes: Ready on the fill side is low only when full

`timescale 1ns/1ps

module beat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready_o = (s_q.count != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (s_q.count != '0);
    assign out_data_o = mem[s_q.rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (pop && !push) begin
            s_d.count = s_q.count - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage needs no reset; only the pointers and count define what is valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[s_q.wr_ptr] <= in_data_i;
        end
    end

endmodule

//--- pin_control.sv
// Purpose: Command, clock gate, termination and mask pin handling of a DRAM
// Assumes: CLK_CROSS_I pulses once per rising crossing of the differential clock
// Notes: Read beats are driven out with a strobe that toggles on every beat

`timescale 1ns/1ps

module pin_control
    import pinctl_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CLK_CROSS_I,
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic ROW_STROBE_N_I,
    input wire logic COL_STROBE_N_I,
    input wire logic WRITE_EN_N_I,
    input wire logic [BANK_W-1:0] BANK_SELECT_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic DIE_TERMINATION_CTL_I,
    input wire logic WSTROBE_EDGE_I,
    input wire logic WRITE_MASK_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    output logic WDATA_READY_O,
    output logic ARRAY_WVALID_O,
    input wire logic ARRAY_WREADY_I,
    output logic [DATA_W-1:0] ARRAY_WDATA_O,
    input wire logic READ_VALID_I,
    input wire logic [DATA_W-1:0] READ_DATA_I,
    output logic [DATA_W-1:0] DQ_O,
    output logic DQ_OE_O,
    output logic DATA_STROBE_O,
    output logic ALT_READ_STROBE_O,
    output logic CMD_VALID_O,
    output cmd_t CMD_O,
    output logic [BANK_W-1:0] CMD_BANK_O,
    output logic [ADDR_W-1:0] CMD_ADDR_O,
    output logic PRECHARGE_ALL_O,
    output logic [NUM_BANKS-1:0] OPEN_BANKS_O,
    output pwr_t POWER_STATE_O,
    output logic INTERNAL_CLK_EN_O,
    output logic CLK_BUF_EN_O,
    output logic CTRL_BUF_EN_O,
    output logic TERMINATION_EN_O,
    output logic MASK_PIN_IS_STROBE_O
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        pwr_t pwr;
        logic cke;
        logic [NUM_BANKS-1:0] open_banks;
        logic die_termination_ctl;
        logic [1:0] emr1_term;
        logic emr1_alt_strobe;
        logic cmd_valid;
        cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic pre_all;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
        logic dqs;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    cmd_t cmd_now;
    logic bufs_on;
    logic mask_hit;
    logic fifo_in_valid;

    cmd_decode u_decode (
        .cs_n_i(CS_N_I),
        .row_strobe_n_i(ROW_STROBE_N_I),
        .col_strobe_n_i(COL_STROBE_N_I),
        .write_en_n_i(WRITE_EN_N_I),
        .cmd_o(cmd_now)
    );

    // ****************************************
    // Write beat path
    // ****************************************
    // Mask only counts while the pin works as write mask, not as a read strobe
    assign bufs_on = (s_q.pwr == PWR_ACTIVE);
    assign mask_hit = WRITE_MASK_I && !s_q.emr1_alt_strobe;
    // Every strobe edge in the active power state, rising or falling, samples mask with its beat
    assign fifo_in_valid = WSTROBE_EDGE_I && bufs_on && !mask_hit;

    beat_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(WDATA_READY_O),
        .in_data_i(WDATA_I),
        .out_valid_o(ARRAY_WVALID_O),
        .out_ready_i(ARRAY_WREADY_I),
        .out_data_o(ARRAY_WDATA_O)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.cmd_valid = 1'b0;
        // Self refresh exit needs no crossing: the clock may be stopped
        if (s_q.pwr == PWR_SELF_REFRESH) begin
            if (CKE_I) begin
                s_d.pwr = PWR_ACTIVE;
                s_d.cke = 1'b1;
            end
        end else if (CLK_CROSS_I) begin
            s_d.cke = CKE_I;
            unique case (s_q.pwr)
                PWR_ACTIVE: begin
                    if (!CKE_I) begin
                        if (s_q.open_banks != '0) begin
                            s_d.pwr = PWR_ACTIVE_PD;
                        end else if (cmd_now == CMD_REFRESH && s_q.cke) begin
                            s_d.pwr = PWR_SELF_REFRESH;
                        end else begin
                            s_d.pwr = PWR_PRECHARGE_PD;
                        end
                    end else begin
                        s_d.die_termination_ctl = DIE_TERMINATION_CTL_I;
                        s_d.cmd_valid = (cmd_now != CMD_DESELECT) && (cmd_now != CMD_NOP);
                        s_d.cmd = cmd_now;
                        s_d.bank = BANK_SELECT_I;
                        s_d.addr = ADDR_I;
                        s_d.pre_all = ADDR_I[PRECHARGE_ALL_POS];
                        unique case (cmd_now)
                            CMD_ACTIVATE: s_d.open_banks[BANK_SELECT_I] = 1'b1;
                            CMD_PRECHARGE: begin
                                if (ADDR_I[PRECHARGE_ALL_POS]) begin
                                    s_d.open_banks = '0;
                                end else begin
                                    s_d.open_banks[BANK_SELECT_I] = 1'b0;
                                end
                            end
                            CMD_MODE_SET: begin
                                if (BANK_SELECT_I == EXT_MODE_REG_ONE_SEL) begin
                                    s_d.emr1_term = {ADDR_I[EMR1_TERM_HI_POS],
                                                     ADDR_I[EMR1_TERM_LO_POS]};
                                    s_d.emr1_alt_strobe = ADDR_I[EMR1_ALT_STROBE_POS];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                PWR_PRECHARGE_PD, PWR_ACTIVE_PD: begin
                    if (CKE_I) begin
                        s_d.pwr = PWR_ACTIVE;
                    end
                end
                default: begin
                end
            endcase
        end
        // Read beats: strobe flips on each beat so data follows both crossings
        if (READ_VALID_I && bufs_on) begin
            s_d.dq = READ_DATA_I;
            s_d.dq_oe = 1'b1;
            s_d.dqs = !s_q.dqs;
        end else begin
            s_d.dq_oe = 1'b0;
        end
        if (!bufs_on) begin
            s_d.die_termination_ctl = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            s_q <= '0;
            s_q.pwr <= PWR_ACTIVE;
            s_q.cke <= 1'b1;
            s_q.open_banks <= OPEN_BANKS_RESET;
            s_q.emr1_term <= EMR1_TERM_RESET;
            s_q.emr1_alt_strobe <= EMR1_ALT_STROBE_RESET;
            s_q.cmd <= CMD_DESELECT;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign CMD_VALID_O = s_q.cmd_valid;
    assign CMD_O = s_q.cmd;
    assign CMD_BANK_O = s_q.bank;
    assign CMD_ADDR_O = s_q.addr;
    assign PRECHARGE_ALL_O = s_q.pre_all;
    assign OPEN_BANKS_O = s_q.open_banks;
    assign POWER_STATE_O = s_q.pwr;
    assign DQ_O = s_q.dq;
    assign DQ_OE_O = s_q.dq_oe;
    assign DATA_STROBE_O = s_q.dqs;
    assign ALT_READ_STROBE_O = s_q.dqs && s_q.emr1_alt_strobe;
    assign MASK_PIN_IS_STROBE_O = s_q.emr1_alt_strobe;
    assign INTERNAL_CLK_EN_O = bufs_on;
    assign CLK_BUF_EN_O = (s_q.pwr != PWR_SELF_REFRESH);
    assign CTRL_BUF_EN_O = bufs_on;
    // Both enable bits clear means termination is off regardless of the pin
    assign TERMINATION_EN_O = s_q.die_termination_ctl && (s_q.emr1_term != 2'h0);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    sequence s_deselect_seen;
        CLK_CROSS_I && CKE_I && CS_N_I && s_q.pwr == PWR_ACTIVE;
    endsequence

    sequence s_any_taken;
        CLK_CROSS_I && CKE_I && !CS_N_I && s_q.pwr == PWR_ACTIVE;
    endsequence

    // Selected command with a given strobe code, taken at a crossing
    sequence s_cmd_code(logic [2:0] code);
        CLK_CROSS_I && CKE_I && !CS_N_I && s_q.pwr == PWR_ACTIVE
            && {ROW_STROBE_N_I, COL_STROBE_N_I, WRITE_EN_N_I} == code;
    endsequence

    // Refresh code as the gate falls, gate high before, every bank closed
    sequence s_sr_request;
        CLK_CROSS_I && !CKE_I && s_q.cke && !CS_N_I && s_q.pwr == PWR_ACTIVE
            && s_q.open_banks == '0 && {ROW_STROBE_N_I, COL_STROBE_N_I, WRITE_EN_N_I} == 3'h1;
    endsequence

    a_deselect_ignored: assert property (s_deselect_seen |=> !CMD_VALID_O)
        else $error("Command issued while chip select high");
    a_no_cross_no_cmd: assert property (!CLK_CROSS_I |=> !CMD_VALID_O)
        else $error("Command captured without clock crossing");
    a_sr_exit_async: assert property (s_q.pwr == PWR_SELF_REFRESH && CKE_I
        |=> POWER_STATE_O == PWR_ACTIVE)
        else $error("Self refresh exit missed");
    a_sr_entry: assert property (s_sr_request
        |=> POWER_STATE_O == PWR_SELF_REFRESH)
        else $error("Self refresh not entered");
    a_pd_active_entry: assert property (CLK_CROSS_I && !CKE_I
        && s_q.pwr == PWR_ACTIVE && s_q.open_banks != '0 |=> POWER_STATE_O == PWR_ACTIVE_PD)
        else $error("Active power-down not entered");
    a_pd_no_cross: assert property (s_q.pwr == PWR_PRECHARGE_PD && !CLK_CROSS_I
        |=> POWER_STATE_O == PWR_PRECHARGE_PD)
        else $error("Power-down left without crossing");
    a_gate_low_quiet: assert property (s_q.pwr != PWR_ACTIVE
        |=> !DQ_OE_O && !CMD_VALID_O)
        else $error("Activity while clock gate low");
    a_pd_buffers: assert property (POWER_STATE_O == PWR_ACTIVE_PD
        || POWER_STATE_O == PWR_PRECHARGE_PD |-> CLK_BUF_EN_O && !CTRL_BUF_EN_O)
        else $error("Wrong buffers in power-down");
    a_mask_drops_beat: assert property (WSTROBE_EDGE_I && WRITE_MASK_I
        && !s_q.emr1_alt_strobe |-> !fifo_in_valid)
        else $error("Masked beat stored");
    a_mask_keeps_empty: assert property (WSTROBE_EDGE_I && WRITE_MASK_I
        && !s_q.emr1_alt_strobe && !ARRAY_WVALID_O |=> !ARRAY_WVALID_O)
        else $error("Masked beat reached the array side");
    a_term_disabled: assert property (s_q.emr1_term == 2'h0 |-> !TERMINATION_EN_O)
        else $error("Termination on while disabled");
    a_term_follows: assert property (s_cmd_code(3'h7) ##0 DIE_TERMINATION_CTL_I
        ##0 s_q.emr1_term != 2'h0 |=> TERMINATION_EN_O)
        else $error("Termination request not honoured");
    a_read_strobe_flip: assert property (READ_VALID_I && bufs_on
        |=> DQ_OE_O && DATA_STROBE_O != $past(DATA_STROBE_O))
        else $error("Read beat without strobe transition");
    a_cmd_fields: assert property (s_any_taken
        |=> CMD_BANK_O == $past(BANK_SELECT_I) && CMD_ADDR_O == $past(ADDR_I))
        else $error("Command bank or address not captured");
    a_activate_opens: assert property (s_cmd_code(3'h3)
        |=> CMD_VALID_O && CMD_O == CMD_ACTIVATE && OPEN_BANKS_O[$past(BANK_SELECT_I)])
        else $error("Activate did not open its bank");
    a_precharge_all: assert property (s_cmd_code(3'h2)
        ##0 ADDR_I[PRECHARGE_ALL_POS] |=> OPEN_BANKS_O == '0)
        else $error("Precharge all left a bank open");
    a_bank_precharge: assert property (s_cmd_code(3'h2)
        ##0 !ADDR_I[PRECHARGE_ALL_POS]
        |=> !OPEN_BANKS_O[$past(BANK_SELECT_I)] && !PRECHARGE_ALL_O)
        else $error("Single precharge left its bank open");
    a_ext_reg_write: assert property (s_cmd_code(3'h0)
        ##0 BANK_SELECT_I == EXT_MODE_REG_ONE_SEL
        |=> MASK_PIN_IS_STROBE_O == $past(ADDR_I[EMR1_ALT_STROBE_POS]))
        else $error("Extended register write not applied");
    a_other_reg_kept: assert property (s_cmd_code(3'h0)
        ##0 BANK_SELECT_I != EXT_MODE_REG_ONE_SEL |=> $stable(MASK_PIN_IS_STROBE_O))
        else $error("Mode set to another register changed the pin mode");
    a_buffers_off_sr: assert property (POWER_STATE_O == PWR_SELF_REFRESH
        |-> !CLK_BUF_EN_O && !CTRL_BUF_EN_O)
        else $error("Buffers on in self refresh");

endmodule

//--- ctrl_model.sv
// Purpose: Behavioural memory controller that drives the command and write pins
// Assumes: Pins change only just after a rising clock edge
// Notes: Crossing pulses stop between commands, as a halted link clock would

`timescale 1ns/1ps

module ctrl_model
    import pinctl_pkg::*;
(
    input wire logic clk_i,
    output logic take_o,
    output logic cke_o,
    output logic cs_n_o,
    output logic row_n_o,
    output logic col_n_o,
    output logic we_n_o,
    output logic [BANK_W-1:0] bank_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic odt_o,
    output logic wedge_o,
    output logic wmask_o,
    output logic [DATA_W-1:0] wdata_o
);
    // ****************************************
    // Idle pin levels
    // ****************************************
    initial begin
        {take_o, cke_o, cs_n_o, row_n_o, col_n_o, we_n_o, odt_o, wedge_o, wmask_o} = 9'h0F8;
        bank_o = 3'h0;
        addr_o = 14'h0000;
        wdata_o = 8'h00;
    end

    // ****************************************
    // Command cycle: pins held across the crossing
    // ****************************************
    task automatic cmd(input logic take, input logic cke, input logic [3:0] code,
                       input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr);
        @(posedge clk_i);
        take_o <= take;
        cke_o <= cke;
        {cs_n_o, row_n_o, col_n_o, we_n_o} <= code;
        bank_o <= bank;
        addr_o <= addr;
        @(posedge clk_i);
        take_o <= 1'h0;
        {cs_n_o, row_n_o, col_n_o, we_n_o} <= 4'hF;
    endtask

    // Self refresh exit needs no crossing
    task automatic gate(input logic v);
        @(posedge clk_i);
        cke_o <= v;
    endtask

    task automatic term(input logic v);
        @(posedge clk_i);
        odt_o <= v;
    endtask

    // Back to back calls keep the edge pulse high, one beat per strobe edge
    task automatic beat(input logic m, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        wedge_o <= 1'h1;
        wmask_o <= m;
        wdata_o <= d;
    endtask

    // Data lines flip after the beat so stale values cannot pass for fresh ones
    task automatic beat_end;
        @(posedge clk_i);
        wedge_o <= 1'h0;
        wmask_o <= ~wmask_o;
        wdata_o <= ~wdata_o;
    endtask
endmodule

//--- pin_control_tb.sv
// Purpose: Self-checking bench for the DRAM pin control block
// Assumes: Controller model drives the command side; bench drives the array side
// Notes: Scenarios run in a fixed order; write beats run before alternate strobe mode

`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t ns: %s", $time, m); end end

module pin_control_tb
    import pinctl_pkg::*;
;
    localparam logic [3:0] OP_NOP = 4'h7;
    localparam logic [3:0] OP_ACT = 4'h3;
    localparam logic [3:0] OP_PRE = 4'h2;
    localparam logic [3:0] OP_REF = 4'h1;
    localparam logic [3:0] OP_MRS = 4'h0;
    logic clk = 1'h0;
    logic rst, xing, cke, cs_n, row_n, col_n, we_n, die_termination_ctl, wedge, wmask, wready, rvalid;
    logic wrdy, awvalid, dq_oe, dstrobe, alt_strobe, cvalid, pre_all;
    logic clk_en, clkbuf_en, ctrlbuf_en, term_en, mask_strobe;
    logic [BANK_W-1:0] bank, cbank;
    logic [ADDR_W-1:0] addr, caddr;
    logic [DATA_W-1:0] wdata, awdata, rdata, dq;
    logic [NUM_BANKS-1:0] open_banks;
    cmd_t cmd;
    pwr_t pwr;
    int mismatches = 0;
    int comparisons = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    ctrl_model FAR (
        .clk_i(clk), .take_o(xing), .cke_o(cke), .cs_n_o(cs_n), .row_n_o(row_n),
        .col_n_o(col_n), .we_n_o(we_n), .bank_o(bank), .addr_o(addr), .odt_o(die_termination_ctl),
        .wedge_o(wedge), .wmask_o(wmask), .wdata_o(wdata)
    );

    pin_control DUT (
        .CLOCK_I(clk), .RST_I(rst), .CLK_CROSS_I(xing), .CKE_I(cke), .CS_N_I(cs_n),
        .ROW_STROBE_N_I(row_n), .COL_STROBE_N_I(col_n), .WRITE_EN_N_I(we_n),
        .BANK_SELECT_I(bank), .ADDR_I(addr), .DIE_TERMINATION_CTL_I(die_termination_ctl),
        .WSTROBE_EDGE_I(wedge), .WRITE_MASK_I(wmask), .WDATA_I(wdata),
        .WDATA_READY_O(wrdy), .ARRAY_WVALID_O(awvalid), .ARRAY_WREADY_I(wready),
        .ARRAY_WDATA_O(awdata), .READ_VALID_I(rvalid), .READ_DATA_I(rdata), .DQ_O(dq),
        .DQ_OE_O(dq_oe), .DATA_STROBE_O(dstrobe), .ALT_READ_STROBE_O(alt_strobe),
        .CMD_VALID_O(cvalid), .CMD_O(cmd), .CMD_BANK_O(cbank), .CMD_ADDR_O(caddr),
        .PRECHARGE_ALL_O(pre_all), .OPEN_BANKS_O(open_banks), .POWER_STATE_O(pwr),
        .INTERNAL_CLK_EN_O(clk_en), .CLK_BUF_EN_O(clkbuf_en), .CTRL_BUF_EN_O(ctrlbuf_en),
        .TERMINATION_EN_O(term_en), .MASK_PIN_IS_STROBE_O(mask_strobe)
    );

    // ****************************************
    // Scenarios
    // ****************************************
    task cmd_codes;
        cmd_t exp [8];
        exp = '{CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE, CMD_WRITE,
                CMD_READ, CMD_NOP, CMD_NOP};
        for (int i = 0; i < 8; i++) begin
            if (i == 6)
                continue;
            FAR.cmd(1'h1, 1'h1, 4'h8 | 4'(i), 3'h4, 14'h2A5A);
            #1;
            `CHK(cvalid, 1'h0, "deselected command")
            FAR.cmd(1'h1, 1'h1, 4'(i), 3'h4, 14'h2A5A);
            #1;
            `CHK(cvalid, 1'(i != 7), "command pulse")
            if (i != 7) begin
                `CHK(cmd, exp[i], "command code")
                `CHK(cbank, 3'h4, "command bank")
                `CHK(caddr, 14'h2A5A, "command address")
            end
        end
        `CHK(open_banks, 8'h10, "bank left open")
        `CHK(mask_strobe, 1'h0, "mode set to other bank")
    endtask

    task bank_ops;
        FAR.cmd(1'h1, 1'h1, OP_ACT, 3'h2, 14'h0123);
        #1;
        `CHK(open_banks, 8'h14, "activate")
        FAR.cmd(1'h1, 1'h1, OP_PRE, 3'h4, 14'h0000);
        #1;
        `CHK(open_banks, 8'h04, "single precharge")
        `CHK(pre_all, 1'h0, "single flag")
        FAR.cmd(1'h1, 1'h1, OP_ACT, 3'h7, 14'h0000);
        FAR.cmd(1'h0, 1'h1, OP_PRE, 3'h2, 14'h0400);
        #1;
        `CHK(cvalid, 1'h0, "no crossing")
        `CHK(open_banks, 8'h84, "no crossing banks")
        FAR.cmd(1'h1, 1'h1, OP_PRE, 3'h2, 14'h0400);
        #1;
        `CHK(open_banks, 8'h00, "precharge all")
        `CHK(pre_all, 1'h1, "all flag")
    endtask

    task power_modes;
        FAR.cmd(1'h1, 1'h1, OP_ACT, 3'h3, 14'h0000);
        FAR.cmd(1'h1, 1'h0, OP_NOP, 3'h0, 14'h0000);
        #1;
        `CHK(pwr, PWR_ACTIVE_PD, "active power-down")
        `CHK({clk_en, clkbuf_en, ctrlbuf_en}, 3'h2, "power-down buffers")
        FAR.cmd(1'h1, 1'h0, OP_ACT, 3'h5, 14'h0000);
        #1;
        `CHK(cvalid, 1'h0, "command in power-down")
        `CHK(open_banks, 8'h08, "banks in power-down")
        FAR.cmd(1'h1, 1'h1, OP_NOP, 3'h0, 14'h0000);
        #1;
        `CHK(pwr, PWR_ACTIVE, "power-down exit")
        FAR.cmd(1'h1, 1'h1, OP_PRE, 3'h0, 14'h0400);
        FAR.cmd(1'h1, 1'h0, OP_NOP, 3'h0, 14'h0000);
        #1;
        `CHK(pwr, PWR_PRECHARGE_PD, "precharge power-down")
        FAR.cmd(1'h1, 1'h1, OP_NOP, 3'h0, 14'h0000);
        FAR.cmd(1'h1, 1'h0, OP_REF, 3'h0, 14'h0000);
        #1;
        `CHK(pwr, PWR_SELF_REFRESH, "self refresh")
        `CHK({clk_en, clkbuf_en, ctrlbuf_en}, 3'h0, "self refresh buffers")
        repeat (4) @(posedge clk);
        FAR.gate(1'h1);
        @(posedge clk);
        #1;
        `CHK(pwr, PWR_ACTIVE, "self refresh exit")
        `CHK({clk_en, clkbuf_en, ctrlbuf_en}, 3'h7, "buffers on")
    endtask

    // Array side stalls while the buffer fills; beat 5 is masked, beat 17 finds it full
    task write_fill;
        for (int i = 0; i < 18; i++)
            FAR.beat(1'(i == 5), 8'h30 + 8'(i));
        FAR.beat_end;
        @(posedge clk);
        #1;
        `CHK(wrdy, 1'h0, "buffer full")
        @(posedge clk);
        wready <= 1'h1;
        #1;
        for (int i = 0; i < 17; i++) begin
            if (i == 5)
                continue;
            `CHK(awvalid, 1'h1, "beat present")
            `CHK(awdata, 8'h30 + 8'(i), "beat data")
            @(posedge clk);
            #1;
        end
        `CHK(awvalid, 1'h0, "buffer drained")
        `CHK(wrdy, 1'h1, "room again")
        FAR.beat(1'h1, 8'h99);
        FAR.beat_end;
        #1;
        `CHK(awvalid, 1'h0, "masked beat dropped")
    endtask

    task term_modes;
        FAR.cmd(1'h1, 1'h1, OP_MRS, 3'h1, 14'h0804);
        #1;
        `CHK(mask_strobe, 1'h1, "alternate strobe mode")
        `CHK(term_en, 1'h0, "no request")
        FAR.term(1'h1);
        FAR.cmd(1'h1, 1'h1, OP_NOP, 3'h0, 14'h0000);
        #1;
        `CHK(term_en, 1'h1, "termination on")
        FAR.cmd(1'h1, 1'h1, OP_MRS, 3'h1, 14'h0040);
        #1;
        `CHK(term_en, 1'h1, "upper termination bit")
        `CHK(mask_strobe, 1'h0, "mask mode again")
        FAR.cmd(1'h1, 1'h1, OP_MRS, 3'h1, 14'h0000);
        #1;
        `CHK(term_en, 1'h0, "termination disabled")
        FAR.term(1'h0);
        FAR.cmd(1'h1, 1'h1, OP_MRS, 3'h1, 14'h0800);
        FAR.beat(1'h1, 8'h77);
        FAR.beat_end;
        #1;
        `CHK(awvalid, 1'h1, "mask pin as strobe")
        `CHK(awdata, 8'h77, "unmasked data")
    endtask

    task read_beats;
        @(posedge clk);
        rvalid <= 1'h1;
        rdata <= 8'hA5;
        @(posedge clk);
        rdata <= 8'h5A;
        #1;
        `CHK({dq, dq_oe, dstrobe, alt_strobe}, 11'h52F, "first read beat")
        @(posedge clk);
        rvalid <= 1'h0;
        rdata <= 8'hA5;
        #1;
        `CHK({dq, dq_oe, dstrobe, alt_strobe}, 11'h2D4, "second read beat")
        @(posedge clk);
        #1;
        `CHK(dq_oe, 1'h0, "driver off")
    endtask

    task wrap_up;
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        rst = 1'h1;
        wready = 1'h0;
        rvalid = 1'h0;
        rdata = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        `CHK(pwr, PWR_ACTIVE, "reset power state")
        `CHK({open_banks, wrdy, dq_oe, dstrobe, cvalid, mask_strobe}, 13'h0010, "reset values")
        cmd_codes;
        bank_ops;
        power_modes;
        write_fill;
        term_modes;
        read_beats;
        wrap_up;
    end

    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
endmodule
